// file: src/mirs_int_regs.sv
// Interrupt control register set: enables, request flags, edge selects and core request.
`timescale 1ns/10ps
`default_nettype none

module mirs_int_regs
  import mirs_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [DATA_W-1:0] regRdData,
  // External interrupt pins, asynchronous
  input wire logic extPin0,
  input wire logic extPin1,
  // Peripheral request pulses, on clk_sys
  input wire logic comparatorEvt,
  input wire logic converterEvt,
  input wire logic timebase0Evt,
  input wire logic timebase1Evt,
  input wire logic serialIfEvt,
  input wire logic asyncSerialEvt,
  input wire logic standardTimerPEvt,
  input wire logic standardTimerAEvt,
  input wire logic periodicTimerPEvt,
  input wire logic periodicTimerAEvt,
  input wire logic compactTimerPEvt,
  input wire logic compactTimerAEvt,
  input wire logic eepromDoneEvt,
  // Low-voltage detector output level, asynchronous
  input wire logic lowVoltLevel,
  // Interrupt outputs
  output logic coreIrqReq,
  output logic sysIrq
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [DATA_W-1:0] edgeSel;
    logic [DATA_W-1:0] prim0;
    logic [DATA_W-1:0] prim1;
    logic [DATA_W-1:0] prim2;
    logic [DATA_W-1:0] grp0;
    logic [DATA_W-1:0] grp1;
    logic [DATA_W-1:0] grp2;
    logic [EVT_W-1:0] evtStat;
    logic [EVT_W-1:0] evtMask;
    logic [DATA_W-1:0] rdData;
    logic lvSync1;
    logic lvSync2;
    logic lvDone;
    mirs_lvcnt_t lvCnt;
    logic coreReq;
  } mirs_state_s;

  mirs_state_s cur;
  mirs_state_s nxt;

  // ==========================================================================
  // External pin edge detection
  logic pin0Hit;
  logic pin1Hit;

  mirs_pin_edge u_pin0 (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pinIn(extPin0),
    .edgeSel(cur.edgeSel[EDGE_PIN0_LSB +: 2]),
    .edgeHit(pin0Hit)
  );

  mirs_pin_edge u_pin1 (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pinIn(extPin1),
    .edgeSel(cur.edgeSel[EDGE_PIN1_LSB +: 2]),
    .edgeHit(pin1Hit)
  );

  // ==========================================================================
  // Write decode
  logic wrEdge;
  logic wrPrim0;
  logic wrPrim1;
  logic wrPrim2;
  logic wrGrp0;
  logic wrGrp1;
  logic wrGrp2;
  logic wrMask;
  logic rdStat;

  assign wrEdge = regWrEn && (regAddr == OFF_EDGE_SEL);
  assign wrPrim0 = regWrEn && (regAddr == OFF_PRIM0);
  assign wrPrim1 = regWrEn && (regAddr == OFF_PRIM1);
  assign wrPrim2 = regWrEn && (regAddr == OFF_PRIM2);
  assign wrGrp0 = regWrEn && (regAddr == OFF_GRP0);
  assign wrGrp1 = regWrEn && (regAddr == OFF_GRP1);
  assign wrGrp2 = regWrEn && (regAddr == OFF_GRP2);
  assign wrMask = regWrEn && (regAddr == OFF_EVT_MASK);
  assign rdStat = regRdEn && (regAddr == OFF_EVT_STAT);

  // ==========================================================================
  // Group summaries and core request
  logic grp0Pend;
  logic grp1Pend;
  logic grp2Pend;
  logic prim0Pend;
  logic anyPend;
  logic lvSet;

  // Group flags follow the enabled sub-requests of their group register.
  assign grp0Pend = pairPend(cur.grp0);
  assign grp1Pend = pairPend(cur.grp1);
  assign grp2Pend = pairPend(cur.grp2);

  // Primary register 0 holds its enables one bit higher than the others.
  assign prim0Pend = |(cur.prim0[6:4] & cur.prim0[3:1]);

  // Grouped sources reach the core only through their group pair, so the
  // group enable gates them as well.
  assign anyPend = cur.prim0[BIT_GLOBAL_EN] &
                   (prim0Pend | pairPend(cur.prim1) | pairPend(cur.prim2));

  assign lvSet = cur.lvSync2 && !cur.lvDone && (cur.lvCnt == LV_DELAY_CYC - 1'b1);

  // ==========================================================================
  // Flag set masks
  logic [DATA_W-1:0] prim0Set;
  logic [DATA_W-1:0] prim1Set;
  logic [DATA_W-1:0] prim2Set;
  logic [DATA_W-1:0] grp0Set;
  logic [DATA_W-1:0] grp1Set;
  logic [DATA_W-1:0] grp2Set;
  logic [EVT_W-1:0] evtSet;

  // Flags latch their request whatever the enable, so software may poll them.
  assign prim0Set = {1'b0, grp0Pend, comparatorEvt, pin0Hit, 4'h0};
  assign prim1Set = {timebase0Evt, converterEvt, grp2Pend, grp1Pend, 4'h0};
  assign prim2Set = {asyncSerialEvt, serialIfEvt, pin1Hit, timebase1Evt, 4'h0};
  assign grp0Set = {2'b00, standardTimerAEvt, standardTimerPEvt, 4'h0};
  assign grp1Set = {compactTimerAEvt, compactTimerPEvt,
                    periodicTimerAEvt, periodicTimerPEvt, 4'h0};
  assign grp2Set = {2'b00, eepromDoneEvt, lvSet, 4'h0};

  always_comb begin
    evtSet = RST_EVT;
    evtSet[EVT_PIN0] = pin0Hit;
    evtSet[EVT_PIN1] = pin1Hit;
    evtSet[EVT_LOW_VOLT] = lvSet;
    evtSet[EVT_CORE_REQ] = anyPend & ~cur.coreReq;
  end

  // ==========================================================================
  // Next state
  always_comb begin
    nxt = cur;

    // Edge selects: only the low nibble exists.
    nxt.edgeSel = nextReg(cur.edgeSel, wrEdge, regWrData, RST_REG, IMPL_EDGE);

    // Primary registers; writes set or clear flags, hardware sets win.
    nxt.prim0 = nextReg(cur.prim0, wrPrim0, regWrData, prim0Set, IMPL_PRIM0);
    nxt.prim1 = nextReg(cur.prim1, wrPrim1, regWrData, prim1Set, IMPL_FULL);
    nxt.prim2 = nextReg(cur.prim2, wrPrim2, regWrData, prim2Set, IMPL_FULL);

    // Group registers.
    nxt.grp0 = nextReg(cur.grp0, wrGrp0, regWrData, grp0Set, IMPL_GRP_HALF);
    nxt.grp1 = nextReg(cur.grp1, wrGrp1, regWrData, grp1Set, IMPL_FULL);
    nxt.grp2 = nextReg(cur.grp2, wrGrp2, regWrData, grp2Set, IMPL_GRP_HALF);

    // Event status clears on read; an event in the same cycle survives.
    nxt.evtStat = (cur.evtStat & ~{EVT_W{rdStat}}) | evtSet;
    if (wrMask) begin
      nxt.evtMask = regWrData[EVT_W-1:0];
    end

    // Low-voltage level crossing and delay before the flag sets.
    nxt.lvSync1 = lowVoltLevel;
    nxt.lvSync2 = cur.lvSync1;
    if (!cur.lvSync2) begin
      nxt.lvCnt = '0;
      nxt.lvDone = 1'b0;
    end else if (!cur.lvDone) begin
      if (lvSet) begin
        nxt.lvDone = 1'b1;
      end else begin
        nxt.lvCnt = cur.lvCnt + 1'b1;
      end
    end

    nxt.coreReq = anyPend;

    // Read data stand for exactly one cycle after the strobe.
    nxt.rdData = RST_REG;
    if (regRdEn) begin
      unique case (regAddr)
        OFF_EDGE_SEL: nxt.rdData = cur.edgeSel & IMPL_EDGE;
        OFF_PRIM0: nxt.rdData = cur.prim0 & IMPL_PRIM0;
        OFF_PRIM1: nxt.rdData = cur.prim1;
        OFF_PRIM2: nxt.rdData = cur.prim2;
        OFF_GRP0: nxt.rdData = cur.grp0 & IMPL_GRP_HALF;
        OFF_GRP1: nxt.rdData = cur.grp1;
        OFF_GRP2: nxt.rdData = cur.grp2 & IMPL_GRP_HALF;
        OFF_EVT_STAT: nxt.rdData = {4'h0, cur.evtStat};
        OFF_EVT_MASK: nxt.rdData = {4'h0, cur.evtMask};
        default: nxt.rdData = RST_REG;
      endcase
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  // ==========================================================================
  // Outputs
  assign regRdData = cur.rdData;
  assign coreIrqReq = cur.coreReq;
  assign sysIrq = |(cur.evtStat & cur.evtMask);

endmodule

`default_nettype wire

// file: src/mirs_pkg.sv
// Constants, types and helper functions of the interrupt control register set.
//
// Summary of operation
// - Three primary registers hold the primary interrupt enable and request bits.
// - Three group registers hold per-source enables and request flags of grouped sources.
// - Every source has a writable enable, 1 enables, and a flag, 1 means request.
// - Pin trigger select: 00 off, 01 rising, 10 falling, 11 both edges.
// - Edge-select bits 7 to 4 and primary register 0 bit 7 read zero.
// - Three group enable/flag pairs in primary registers summarise each group register.
// - Two time bases have enable and flag; time base 0 at bits 3 and 7.
// - Converter flag is bit 6, enable bit 2 of primary register 1.
// - Comparator flag is bit 5, enable bit 2 of primary register 0.
// - Group 2 enable is bit 1, flag bit 5 of primary register 1.
// - EEPROM completion enable and flag sit in group register 2, bits 1 and 5.
// - Global enable is bit 0 of primary register 0; names follow source-index-suffix.
// - Low-voltage flag sets only a fixed delay after the low-voltage output asserts.

package mirs_pkg;

  // ==========================================================================
  // Register port geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int EVT_W = 4;
  localparam int LV_CNT_W = 8;

  // ==========================================================================
  // Register offsets
  localparam logic [ADDR_W-1:0] OFF_EDGE_SEL = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_PRIM0 = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_PRIM1 = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_PRIM2 = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_GRP0 = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_GRP1 = 4'h5;
  localparam logic [ADDR_W-1:0] OFF_GRP2 = 4'h6;
  localparam logic [ADDR_W-1:0] OFF_EVT_STAT = 4'h7;
  localparam logic [ADDR_W-1:0] OFF_EVT_MASK = 4'h8;

  // ==========================================================================
  // Implemented bits and reset values
  localparam logic [DATA_W-1:0] IMPL_EDGE = 8'h0F;
  localparam logic [DATA_W-1:0] IMPL_PRIM0 = 8'h7F;
  localparam logic [DATA_W-1:0] IMPL_FULL = 8'hFF;
  localparam logic [DATA_W-1:0] IMPL_GRP_HALF = 8'h33;
  localparam logic [DATA_W-1:0] RST_REG = 8'h00;
  localparam logic [EVT_W-1:0] RST_EVT = 4'h0;

  // ==========================================================================
  // Field positions
  localparam int BIT_GLOBAL_EN = 0;
  localparam int EDGE_PIN0_LSB = 0;
  localparam int EDGE_PIN1_LSB = 2;
  localparam int EVT_PIN0 = 0;
  localparam int EVT_PIN1 = 1;
  localparam int EVT_LOW_VOLT = 2;
  localparam int EVT_CORE_REQ = 3;

  // ==========================================================================
  // Low-voltage flag delay
  localparam int CLK_PERIOD_NS = 8;
  localparam int LV_DELAY_NS = 120;
  typedef logic [LV_CNT_W-1:0] mirs_lvcnt_t;
  localparam mirs_lvcnt_t LV_DELAY_CYC =
    mirs_lvcnt_t'((LV_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ==========================================================================
  // Pin trigger selection
  typedef enum logic [1:0] {
    EDGE_OFF = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_BOTH = 2'b11
  } mirs_edge_e;

  // ==========================================================================
  // Helpers
  // A register with enables in bits 3..0 and their flags in bits 7..4.
  function automatic logic pairPend(input logic [DATA_W-1:0] r);
    pairPend = |(r[7:4] & r[3:0]);
  endfunction

  // Software write first, then hardware sets on top, so a set wins a clear.
  function automatic logic [DATA_W-1:0] nextReg(input logic [DATA_W-1:0] cur,
                                                input logic wr,
                                                input logic [DATA_W-1:0] wdata,
                                                input logic [DATA_W-1:0] setMask,
                                                input logic [DATA_W-1:0] impl);
    nextReg = ((wr ? wdata : cur) | setMask) & impl;
  endfunction

endpackage

// file: src/mirs_pin_edge.sv
// External interrupt pin synchroniser and trigger-edge detector.
`timescale 1ns/10ps
`default_nettype none

module mirs_pin_edge
  import mirs_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Pin and selection
  input wire logic pinIn,
  input wire logic [1:0] edgeSel,
  // Detected edge, one-cycle pulse
  output logic edgeHit
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic hit;
  } mirs_pin_s;

  mirs_pin_s cur;
  mirs_pin_s nxt;
  logic rise;
  logic fall;

  assign rise = cur.sync2 & ~cur.prev;
  assign fall = ~cur.sync2 & cur.prev;

  always_comb begin
    nxt = cur;
    nxt.sync1 = pinIn;
    nxt.sync2 = cur.sync1;
    nxt.prev = cur.sync2;
    unique case (mirs_edge_e'(edgeSel))
      EDGE_OFF: nxt.hit = 1'b0;
      EDGE_RISE: nxt.hit = rise;
      EDGE_FALL: nxt.hit = fall;
      EDGE_BOTH: nxt.hit = rise | fall;
    endcase
  end

  // The edge history keeps tracking while the pin is disabled, so enabling a
  // trigger never reports a stale edge.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  assign edgeHit = cur.hit;

endmodule

`default_nettype wire

// file: tb/mirs_src_model.sv
// Peripheral request sources that raise one-cycle request pulses on the system clock.
`timescale 1ns/10ps
`default_nettype none
module mirs_src_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Request commands and pulses
  input wire logic [12:0] trig,
  output logic [12:0] evt
);
  // Registered so that a pulse never reaches the block inside the edge that raised it.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      evt <= '0;
    end else begin
      evt <= trig;
    end
  end
endmodule
`default_nettype wire

// file: tb/mirs_int_regs_sva.sv
// Port checker of the interrupt control register set.
`timescale 1ns/10ps
`default_nettype none
module mirs_int_regs_chk
  import mirs_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [DATA_W-1:0] regRdData,
  // Sources and outputs
  input wire logic comparatorEvt,
  input wire logic coreIrqReq,
  input wire logic sysIrq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Shadows of bits only software can change, so gating is judged from the ports alone.
  logic gEn_reg;
  logic [3:0] mask_reg;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gEn_reg <= 1'b0;
      mask_reg <= 4'h0;
    end else if (regWrEn && regAddr == OFF_PRIM0) begin
      gEn_reg <= regWrData[0];
    end else if (regWrEn && regAddr == OFF_EVT_MASK) begin
      mask_reg <= regWrData[3:0];
    end
  end
  property p_rdIdle;
    !$past(regRdEn) |-> regRdData == 8'h00;
  endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data outside slot");
  property p_unmapped;
    regRdEn && regAddr > OFF_EVT_MASK |=> regRdData == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
  property p_edgeHigh;
    regRdEn && regAddr == OFF_EDGE_SEL |=> regRdData[7:4] == 4'h0;
  endproperty
  a_edgeHigh: assert property (p_edgeHigh) else $error("edge select high bits");
  property p_prim0Top;
    regRdEn && regAddr == OFF_PRIM0 |=> !regRdData[7];
  endproperty
  a_prim0Top: assert property (p_prim0Top) else $error("primary 0 bit 7 set");
  property p_grpGap;
    regRdEn && (regAddr == OFF_GRP0 || regAddr == OFF_GRP2) |=> (regRdData & 8'hCC) == 8'h00;
  endproperty
  a_grpGap: assert property (p_grpGap) else $error("group gap bits set");
  property p_enBack;
    regWrEn && regAddr == OFF_PRIM2 ##1 regRdEn && regAddr == OFF_PRIM2
      |=> regRdData[3:0] == $past(regWrData[3:0], 2);
  endproperty
  a_enBack: assert property (p_enBack) else $error("enables not kept");
  property p_cmpFlag;
    comparatorEvt ##1 regRdEn && regAddr == OFF_PRIM0 |=> regRdData[5];
  endproperty
  a_cmpFlag: assert property (p_cmpFlag) else $error("comparator flag lost");
  property p_global;
    !gEn_reg && !$past(gEn_reg) |-> !coreIrqReq;
  endproperty
  a_global: assert property (p_global) else $error("request without global");
  property p_masked;
    mask_reg == 4'h0 |-> !sysIrq;
  endproperty
  a_masked: assert property (p_masked) else $error("interrupt while masked");
endmodule
bind mirs_int_regs mirs_int_regs_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
  .regRdData(regRdData), .comparatorEvt(comparatorEvt), .coreIrqReq(coreIrqReq),
  .sysIrq(sysIrq));
`default_nettype wire

// file: tb/tb_mirs_int_regs.sv
// Self-checking bench of the interrupt control register set.
`timescale 1ns/10ps
`default_nettype none
module tb_mirs_int_regs import mirs_pkg::*;;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWrData = 8'h00;
  logic [7:0] regRdData;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic extPin0 = 1'b0;
  logic extPin1 = 1'b0;
  logic lowVoltLevel = 1'b0;
  logic coreIrqReq;
  logic sysIrq;
  logic [12:0] trig = '0;
  logic [12:0] evt;
  int err_count = 0;
  int num_checks = 0;
  localparam logic [3:0] SRC_A [13] = '{1, 2, 2, 3, 3, 3, 4, 4, 5, 5, 5, 5, 6};
  localparam int SRC_B [13] = '{5, 6, 7, 4, 6, 7, 4, 5, 4, 5, 6, 7, 5};
  localparam logic [7:0] IMPL [9] = '{8'h0F, 8'h7F, 8'hFF, 8'hFF, 8'h33, 8'hFF, 8'h33, 0, 8'h0F};
  mirs_src_model u_src (.clk_sys(clk_sys), .rst_n(rst_n), .trig(trig), .evt(evt));
  mirs_int_regs u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .extPin0(extPin0), .extPin1(extPin1), .comparatorEvt(evt[0]), .converterEvt(evt[1]),
    .timebase0Evt(evt[2]), .timebase1Evt(evt[3]), .serialIfEvt(evt[4]),
    .asyncSerialEvt(evt[5]), .standardTimerPEvt(evt[6]), .standardTimerAEvt(evt[7]),
    .periodicTimerPEvt(evt[8]), .periodicTimerAEvt(evt[9]), .compactTimerPEvt(evt[10]),
    .compactTimerAEvt(evt[11]), .eepromDoneEvt(evt[12]), .lowVoltLevel(lowVoltLevel),
    .coreIrqReq(coreIrqReq), .sysIrq(sysIrq));
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= v;
    regWrEn <= 1'b1;
    @(posedge clk_sys);
    regWrEn <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk_sys);
    regRdEn <= 1'b0;
    #1;
    v = regRdData;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk(v, exp);
  endtask
  // Write followed at once by a read of the same register, with no idle cycle between.
  task automatic wrrd(input logic [3:0] a, input logic [7:0] v, input logic [7:0] exp);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= v;
    regWrEn <= 1'b1;
    @(posedge clk_sys);
    regWrEn <= 1'b0;
    regRdEn <= 1'b1;
    @(posedge clk_sys);
    regRdEn <= 1'b0;
    #1;
    chk(regRdData, exp);
  endtask
  task automatic fire(input int i);
    @(posedge clk_sys);
    trig <= 13'h0001 << i;
    @(posedge clk_sys);
    trig <= '0;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // A hang ends the run as a failure instead of running on.
  initial begin
    #400000;
    err_count++;
    $display("mismatch at %0t: run did not finish in time", $time);
    give_verdict();
  end
  initial begin
    logic [7:0] fb;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int a = 0; a < 16; a++) rdc(4'(a), 8'h00);
    for (int a = 0; a < 9; a++) begin
      if (a != 7) wrrd(4'(a), 8'hFF, IMPL[a]);
      else wr(4'(a), 8'hFF);
    end
    wt(0);
    chk(coreIrqReq, 1);
    chk(sysIrq, 1);
    rdc(7, 8'h08);
    chk(sysIrq, 0);
    for (int a = 8; a >= 0; a--) begin
      wr(4'(a), 8'h00);
      if (a != 7) rdc(4'(a), 8'h00);
    end
    for (int i = 0; i < 13; i++) begin
      fire(i);
      wt(2);
      rdc(SRC_A[i], 8'h01 << SRC_B[i]);
      chk(coreIrqReq, 0);
      wr(SRC_A[i], 8'h00);
    end
    wr(1, 8'h04);
    fire(0);
    rdc(1, 8'h24);
    chk(coreIrqReq, 0);
    wr(1, 8'h25);
    wt(2);
    chk(coreIrqReq, 1);
    wr(1, 8'h05);
    wt(2);
    chk(coreIrqReq, 0);
    wr(4, 8'h01);
    fire(6);
    wt(2);
    rdc(1, 8'h45);
    chk(coreIrqReq, 0);
    wr(1, 8'h4D);
    wt(2);
    chk(coreIrqReq, 1);
    wr(4, 8'h00);
    wr(1, 8'h00);
    wr(6, 8'h02);
    fire(12);
    wt(2);
    rdc(2, 8'h20);
    wr(6, 8'h00);
    wr(2, 8'h00);
    rdc(7, 8'h08);
    for (int p = 0; p < 2; p++) begin
      fb = p ? 8'h20 : 8'h10;
      for (int m = 0; m < 4; m++) begin
        wr(0, 8'(m << (2 * p)));
        if (p) extPin1 <= 1'b1;
        else extPin0 <= 1'b1;
        wt(6);
        rdc(p ? 4'h3 : 4'h1, m[0] ? fb : 8'h00);
        wr(p ? 4'h3 : 4'h1, 8'h00);
        if (p) extPin1 <= 1'b0;
        else extPin0 <= 1'b0;
        wt(6);
        rdc(p ? 4'h3 : 4'h1, m[1] ? fb : 8'h00);
        wr(p ? 4'h3 : 4'h1, 8'h00);
      end
    end
    rdc(7, 8'h03);
    wr(0, 8'h01);
    extPin0 <= 1'b1;
    wt(6);
    chk(sysIrq, 0);
    wr(8, 8'h01);
    wt(0);
    chk(sysIrq, 1);
    rdc(7, 8'h01);
    chk(sysIrq, 0);
    wr(1, 8'h00);
    lowVoltLevel <= 1'b1;
    wt(12);
    rdc(6, 8'h00);
    wt(10);
    rdc(6, 8'h10);
    rdc(7, 8'h04);
    give_verdict();
  end
endmodule
`default_nettype wire
